/* File: rtl/sgpsc_pkg.sv */
package sgpsc_pkg;

	// ****************************************************************
	// Opcodes and command block fields
	// ****************************************************************
	localparam logic [7:0] OP_PAR_POLL = 8'hD0;  // Conduct a parallel poll.
	localparam logic [7:0] OP_SENSE    = 8'h03;  // Return sense data.
	localparam logic [7:0] OP_SYS_CTL  = 8'hD1;  // Request or release system control.
	localparam int         CDB_LEN     = 6;      // Command block length in bytes.
	localparam int         CDB_ALLOC   = 4;      // Byte holding the allocation count.
	localparam int         CDB_MODE    = 3;      // Byte holding the mode flag.
	localparam int         MODE_BIT    = 0;      // Position of the mode flag.

	// ****************************************************************
	// Sense data layout
	// ****************************************************************
	localparam logic [4:0] SENSE_LEN   = 5'h16;  // Sense bytes available (22).
	localparam logic [7:0] SENSE_HDR   = 8'h70;  // Byte 0: class 7, code 0.
	localparam logic [7:0] SENSE_ADDL  = 8'h0E;  // Byte 7: additional length 14.
	localparam logic [3:0] KEY_NONE    = 4'h0;   // No sense.
	localparam logic [3:0] KEY_ILLEGAL = 4'h5;   // Illegal opcode or parameter.
	localparam logic [3:0] KEY_ERROR   = 4'h9;   // Error on last command.
	localparam logic [3:0] KEY_ABORTED = 4'hB;   // Aborted command.

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ     = 250;                          // Core clock rate.
	localparam int IDY_NS      = 2000;                         // Least poll hold, ns.
	localparam int IDY_CYC     = (IDY_NS * CLK_MHZ + 999) / 1000; // Rounded up.
	localparam int IFC_PULSE_CYC = IDY_CYC;                    // Clear pulse length.

	// ****************************************************************
	// Bus phase codes and packed carriers
	// ****************************************************************
	typedef enum logic [2:0] {
		PH_BUS_FREE = 3'h0,
		PH_COMMAND  = 3'h2,
		PH_DATA_IN  = 3'h1,
		PH_STATUS   = 3'h3,
		PH_MSG_IN   = 3'h7
	} sgpsc_phase_t;

	typedef struct packed {
		logic [7:0] busErr;     // Instrument bus error code.
		logic [7:0] linkErr;    // Host link error code.
		logic [15:0] unitStat;  // Unit status word.
		logic [31:0] xferCount; // Transferred byte count.
	} sgpsc_stat_t;

endpackage : sgpsc_pkg

/* File: rtl/sgpsc_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Parallel poll asserts ATN with EOI, samples data.
// - Hold poll two microseconds, stay active controller.
// - Return poll result as one Data In byte.
// - First controller command pulses IFC, asserts REN.
// - Lost control aborts with check condition, error key, when not system controller.
// - Poll and sense: Command, Data In, Status, Message.
// - System control: Command, Status, Message only.
// - Zero allocation sends no sense, no error.
// - Sense ends at smaller of count, 22 bytes.
// - Sense header 70h, zeros, additional length 14.
// - Key, error codes, status, count fill sense.
// - Keys 0, 5, 9, 11 as defined.
// - Only system controller may drive IFC, REN.
// - Foreign IFC obeyed only when not system controller.
// - Power-on default is system controller.
// - Message In follows Status; command ends then.
module sgpsc_ctrl (
	input  wire logic                  core_clk,     // Core clock, 250 MHz.
	input  wire logic                  nrst,         // Asynchronous reset, active low.
	input  wire logic                  selected,     // Pulse: initiator has selected us.
	input  wire logic                  hostAck,      // Pulse: host took or gave the current byte.
	input  wire logic [7:0]            hostData,     // Command byte from host.
	input  wire logic [7:0]            gpibDataIn,   // Instrument bus data lines.
	input  wire logic                  ifcIn,        // Foreign interface clear seen.
	input  wire logic                  cicLost,      // Pulse: control was passed away.
	input  wire sgpsc_pkg::sgpsc_stat_t unitStat,    // Status fields for sense data.
	output var  sgpsc_pkg::sgpsc_phase_t busPhase_ff, // Current host bus phase.
	output logic                       req_ff,       // Byte ready for host.
	output logic [7:0]                 tgtData_ff,   // Byte to host.
	output logic                       atnOut_ff,    // ATN drive.
	output logic                       eoiOut_ff,    // EOI drive.
	output logic                       ifcOut_ff,    // IFC drive.
	output logic                       renOut_ff,    // REN drive.
	output logic                       sysCtl_ff,    // System controller role.
	output logic                       cic_ff,       // Controller in charge.
	output logic [3:0]                 senseKey_ff,  // Latest sense key.
	output logic [7:0]                 pollResultByte_ff // Last poll result.
);

	// ****************************************************************
	// Sequencer states
	// ****************************************************************
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_CMD  = 8'h02,
		ST_EXEC = 8'h04,
		ST_IFC  = 8'h08,
		ST_POLL = 8'h10,
		ST_DATA = 8'h20,
		ST_STAT = 8'h40,
		ST_MSG  = 8'h80
	} sgpsc_state_t;

	sgpsc_state_t state_ff;                   // Sequencer state.
	logic [7:0]   cdb_ff [sgpsc_pkg::CDB_LEN]; // Captured command block.
	logic [2:0]   cdbIdx_ff;                  // Command byte index.
	logic [4:0]   dataIdx_ff;                 // Data In byte index.
	logic [4:0]   dataLen_ff;                 // Bytes to send in Data In.
	logic [9:0]   timer_ff;                   // Pulse timer.
	logic         checkCond_ff;               // Status is check condition.
	logic         ifcDone_ff;                 // Controller role already claimed.
	logic [9:0]   idyLen_ff;                  // Cycles that ATN has stood so far.

	// Smaller of allocation count and available sense bytes.
	function automatic logic [4:0] senseCount(input logic [7:0] alloc);
		senseCount = (alloc > 8'(sgpsc_pkg::SENSE_LEN)) ? sgpsc_pkg::SENSE_LEN : alloc[4:0];
	endfunction : senseCount

	// Sense byte at a given index.
	function automatic logic [7:0] senseByte(input logic [4:0] i, input logic [3:0] key,
		input sgpsc_pkg::sgpsc_stat_t s);
		senseByte = 8'h00;
		unique case (i)
			5'd0:  senseByte = sgpsc_pkg::SENSE_HDR;
			5'd2:  senseByte = {4'h0, key};
			5'd7:  senseByte = sgpsc_pkg::SENSE_ADDL;
			5'd8:  senseByte = s.busErr;
			5'd9:  senseByte = s.linkErr;
			5'd10: senseByte = s.unitStat[15:8];
			5'd11: senseByte = s.unitStat[7:0];
			5'd18: senseByte = s.xferCount[31:24];
			5'd19: senseByte = s.xferCount[23:16];
			5'd20: senseByte = s.xferCount[15:8];
			5'd21: senseByte = s.xferCount[7:0];
			default: senseByte = 8'h00;
		endcase
	endfunction : senseByte

	wire logic [7:0] opcode  = cdb_ff[0];
	wire logic       isPoll  = (opcode == sgpsc_pkg::OP_PAR_POLL);
	wire logic       isSense = (opcode == sgpsc_pkg::OP_SENSE);
	wire logic       isSys   = (opcode == sgpsc_pkg::OP_SYS_CTL);

	// ****************************************************************
	// Command sequencer and host bus phases
	// ****************************************************************
	// The sequencer walks each command through its phases; the host
	// acknowledges each byte before the next is presented.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_ff     <= ST_IDLE;
			busPhase_ff  <= sgpsc_pkg::PH_BUS_FREE;
			req_ff       <= 1'b0;
			tgtData_ff   <= 8'h00;
			cdbIdx_ff    <= 3'h0;
			dataIdx_ff   <= 5'h00;
			dataLen_ff   <= 5'h00;
			timer_ff     <= 10'h000;
			checkCond_ff <= 1'b0;
			senseKey_ff  <= sgpsc_pkg::KEY_NONE;
			for (int k = 0; k < sgpsc_pkg::CDB_LEN; k++) begin
				cdb_ff[k] <= 8'h00;
			end
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (selected) begin
						state_ff    <= ST_CMD;
						busPhase_ff <= sgpsc_pkg::PH_COMMAND;
						req_ff      <= 1'b1;
						cdbIdx_ff   <= 3'h0;
					end
				end
				ST_CMD: begin
					if (hostAck) begin
						cdb_ff[cdbIdx_ff] <= hostData;
						if (cdbIdx_ff == 3'(sgpsc_pkg::CDB_LEN - 1)) begin
							req_ff   <= 1'b0;
							state_ff <= ST_EXEC;
						end else begin
							cdbIdx_ff <= cdbIdx_ff + 3'h1;
						end
					end
				end
				ST_EXEC: begin
					checkCond_ff <= 1'b0;
					dataIdx_ff   <= 5'h00;
					if (isSense) begin
						dataLen_ff <= senseCount(cdb_ff[sgpsc_pkg::CDB_ALLOC]);
						state_ff   <= ST_DATA;
					end else if (isSys) begin
						senseKey_ff <= sgpsc_pkg::KEY_NONE;
						state_ff    <= ST_STAT;
					end else if (isPoll) begin
						if (!sysCtl_ff && !cic_ff) begin
							checkCond_ff <= 1'b1;
							senseKey_ff  <= sgpsc_pkg::KEY_ERROR;
							state_ff     <= ST_STAT;
						end else if (sysCtl_ff && (!ifcDone_ff || !cic_ff)) begin
							// claim control
							// Only a system controller may clear the bus to take charge.
							timer_ff <= 10'(sgpsc_pkg::IFC_PULSE_CYC);
							state_ff <= ST_IFC;
						end else begin
							timer_ff <= 10'(sgpsc_pkg::IDY_CYC);
							state_ff <= ST_POLL;
						end
					end else begin
						checkCond_ff <= 1'b1;
						senseKey_ff  <= sgpsc_pkg::KEY_ILLEGAL;
						state_ff     <= ST_STAT;
					end
				end
				ST_IFC: begin
					if (timer_ff == 10'h001) begin
						timer_ff <= 10'(sgpsc_pkg::IDY_CYC);
						state_ff <= ST_POLL;
					end else begin
						timer_ff <= timer_ff - 10'h001;
					end
				end
				ST_POLL: begin
					if (timer_ff == 10'h001) begin
						dataLen_ff  <= 5'h01;
						senseKey_ff <= sgpsc_pkg::KEY_NONE;
						state_ff    <= ST_DATA;
					end else begin
						timer_ff <= timer_ff - 10'h001;
					end
				end
				ST_DATA: begin
					busPhase_ff <= sgpsc_pkg::PH_DATA_IN;
					if (dataIdx_ff == dataLen_ff) begin
						req_ff   <= 1'b0;
						state_ff <= ST_STAT;
					end else if (!req_ff) begin
						req_ff <= 1'b1;
						tgtData_ff <= isPoll ? pollResultByte_ff
							: senseByte(dataIdx_ff, senseKey_ff, unitStat);
					end else if (hostAck) begin
						req_ff     <= 1'b0;
						dataIdx_ff <= dataIdx_ff + 5'h01;
					end
				end
				ST_STAT: begin
					busPhase_ff <= sgpsc_pkg::PH_STATUS;
					tgtData_ff  <= checkCond_ff ? 8'h02 : 8'h00;
					req_ff      <= 1'b1;
					if (req_ff && hostAck) begin
						req_ff   <= 1'b0;
						state_ff <= ST_MSG;
					end
				end
				ST_MSG: begin
					busPhase_ff <= sgpsc_pkg::PH_MSG_IN;
					tgtData_ff  <= 8'h00;
					req_ff      <= 1'b1;
					if (req_ff && hostAck) begin
						req_ff      <= 1'b0;
						busPhase_ff <= sgpsc_pkg::PH_BUS_FREE;
						state_ff    <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Instrument bus lines
	// ****************************************************************
	// The poll drives ATN and EOI together for the whole hold window and
	// latches the data lines on its last cycle, when responses have settled.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			atnOut_ff         <= 1'b0;
			eoiOut_ff         <= 1'b0;
			pollResultByte_ff <= 8'h00;
		end else begin
			// identify message
			// Both lines stand for every poll cycle, so the hold is never one cycle short.
			atnOut_ff <= (state_ff == ST_POLL);
			eoiOut_ff <= (state_ff == ST_POLL);
			if (state_ff == ST_POLL && timer_ff == 10'h001) begin
				pollResultByte_ff <= gpibDataIn;
			end
		end
	end

	// Role tracking: system controller, controller in charge, IFC and REN.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sysCtl_ff  <= 1'b1;
			cic_ff     <= 1'b0;
			ifcDone_ff <= 1'b0;
			ifcOut_ff  <= 1'b0;
			renOut_ff  <= 1'b0;
		end else begin
			if (state_ff == ST_EXEC && isSys) begin
				sysCtl_ff <= cdb_ff[sgpsc_pkg::CDB_MODE][sgpsc_pkg::MODE_BIT];
			end
			ifcOut_ff <= sysCtl_ff && (state_ff == ST_IFC);
			if (!sysCtl_ff) begin
				renOut_ff <= 1'b0;
			end else if (state_ff == ST_IFC) begin
				renOut_ff <= 1'b1;
			end
			if (state_ff == ST_IFC && timer_ff == 10'h001) begin
				cic_ff     <= 1'b1;
				ifcDone_ff <= 1'b1;
			end else if (cicLost) begin
				cic_ff <= 1'b0;
			end else if (ifcIn && !sysCtl_ff) begin
				cic_ff <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	// hold length count
	// The hold is far too long for a repetition, so a counter measures it.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			idyLen_ff <= 10'h000;
		end else if (atnOut_ff) begin
			idyLen_ff <= idyLen_ff + 10'h001;
		end else begin
			idyLen_ff <= 10'h000;
		end
	end

	AST_IDY_PAIR: assert property (@(posedge core_clk) disable iff (!nrst)
		atnOut_ff == eoiOut_ff) else $error("ATN and EOI differ.");
	AST_IDY_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
		$fell(atnOut_ff) |-> idyLen_ff >= 10'(sgpsc_pkg::IDY_CYC))
		else $error("Poll hold short.");
	AST_IFC_ROLE: assert property (@(posedge core_clk) disable iff (!nrst)
		ifcOut_ff |-> $past(sysCtl_ff)) else $error("IFC without role.");
	AST_POLL_ONE: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_ff == ST_DATA && isPoll) |-> dataLen_ff == 5'h01) else $error("Poll len.");
	AST_SENSE_MAX: assert property (@(posedge core_clk) disable iff (!nrst)
		dataLen_ff <= sgpsc_pkg::SENSE_LEN) else $error("Sense too long.");
	AST_SYS_NODATA: assert property (@(posedge core_clk) disable iff (!nrst)
		(busPhase_ff == sgpsc_pkg::PH_DATA_IN) |-> !isSys) else $error("Data on sys.");
	AST_MSG_AFTER: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_ff == ST_STAT && hostAck && req_ff) |=> state_ff == ST_MSG)
		else $error("Status not followed by message.");
	AST_ABORT_KEY: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_ff == ST_EXEC && isPoll && !sysCtl_ff && !cic_ff)
		|=> senseKey_ff == sgpsc_pkg::KEY_ERROR && checkCond_ff) else $error("No abort.");

endmodule : sgpsc_ctrl

`default_nettype wire

/* File: tb/sgpsc_instr_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************************************************
// Instrument bus model
// ****************************************************
module sgpsc_instr_model #(
	parameter logic [7:0] RESP = 8'h5A  // Combined poll answer.
) (
	input  wire logic       clk,        // Core clock.
	input  wire logic       atn,        // ATN from the controller.
	input  wire logic       eoi,        // EOI from the controller.
	output logic      [7:0] dataOut     // Data lines seen by the controller.
);
	logic [7:0] walk_ff = 8'h00;  // Filler that changes every cycle.

	// Outside a poll the lines carry noise, so a late sample matches RESP in only one cycle of 256.
	always_ff @(posedge clk) begin
		walk_ff <= walk_ff + 8'h1D;
	end

	assign dataOut = (atn && eoi) ? RESP : walk_ff;
endmodule : sgpsc_instr_model

`default_nettype wire

/* File: tb/sgpsc_ctrl_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module sgpsc_ctrl_tb;
	localparam logic [7:0] PP_RESP = 8'h5A;  // Poll answer of the instruments.
	logic                    core_clk = 1'b0;
	logic                    nrst, selected, hostAck, ifcIn, cicLost;
	logic [7:0]              hostData, tgtData, pollRes, d;
	wire  [7:0]              gpibDataIn;
	sgpsc_pkg::sgpsc_stat_t  unitStat;
	sgpsc_pkg::sgpsc_phase_t busPhase;
	logic                    req, atn, eoi, ifcOut, renOut, sysCtl, cic;
	logic [3:0]              senseKey;
	int                      fail_count = 0, n_checks = 0, cyc = 0, idyCnt = 0;
	logic                    ifcSeen = 1'b0;
	logic [7:0]              expSense [22];  // Expected sense image.

	sgpsc_ctrl uut (.core_clk(core_clk), .nrst(nrst), .selected(selected),
		.hostAck(hostAck), .hostData(hostData), .gpibDataIn(gpibDataIn),
		.ifcIn(ifcIn), .cicLost(cicLost), .unitStat(unitStat),
		.busPhase_ff(busPhase), .req_ff(req), .tgtData_ff(tgtData),
		.atnOut_ff(atn), .eoiOut_ff(eoi), .ifcOut_ff(ifcOut),
		.renOut_ff(renOut), .sysCtl_ff(sysCtl), .cic_ff(cic),
		.senseKey_ff(senseKey), .pollResultByte_ff(pollRes));

	sgpsc_instr_model #(.RESP(PP_RESP)) instr (.clk(core_clk), .atn(atn),
		.eoi(eoi), .dataOut(gpibDataIn));

	// Clock of 4 ns.
	always #2 core_clk = ~core_clk;

	// Watches poll length and clear pulses, and cuts a hang short.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (atn && eoi) idyCnt <= idyCnt + 1;
		if (ifcOut) ifcSeen <= 1'b1;
		if (cyc == 20000) begin
			fail_count++;
			results();
		end
	end

	task automatic results;
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results

	task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chkByte

	task automatic chkBit(input logic got, input logic exp);
		chkByte({7'h00, got}, {7'h00, exp});
	endtask : chkBit

	// One byte handshake: wait for req, check the phase, then acknowledge.
	task automatic xfer(input sgpsc_pkg::sgpsc_phase_t ph, input logic [7:0] dOut,
		output logic [7:0] dIn);
		for (int n = 0; n < 3000 && req !== 1'b1; n++) begin
			@(posedge core_clk);
			#1;
		end
		chkByte({5'h00, busPhase}, {5'h00, ph});
		dIn = tgtData;
		hostData = dOut;
		hostAck = 1'b1;
		@(posedge core_clk);
		#1;
		hostAck = 1'b0;
		// Let one edge pass so the next call never raises the strobe in the same step.
		@(posedge core_clk);
		#1;
	endtask : xfer

	task automatic cmd(input logic [7:0] op, input logic [7:0] r, input logic [7:0] b3,
		input logic [7:0] b4);
		logic [7:0] cdb [6];
		cdb = '{op, r, r, b3, b4, r};
		selected = 1'b1;
		@(posedge core_clk);
		#1;
		selected = 1'b0;
		for (int i = 0; i < 6; i++) xfer(sgpsc_pkg::PH_COMMAND, cdb[i], d);
	endtask : cmd

	// Status then message, then the bus must be free.
	task automatic fin(input logic [7:0] stat);
		xfer(sgpsc_pkg::PH_STATUS, 8'h00, d);
		chkByte(d, stat);
		xfer(sgpsc_pkg::PH_MSG_IN, 8'h00, d);
		chkByte(d, 8'h00);
		@(posedge core_clk);
		#1;
		chkByte({5'h00, busPhase}, {5'h00, sgpsc_pkg::PH_BUS_FREE});
	endtask : fin

	task automatic sense(input logic [7:0] alloc, input logic [3:0] key);
		cmd(sgpsc_pkg::OP_SENSE, 8'h00, 8'h00, alloc);
		expSense[2] = {4'h0, key};
		for (int i = 0; i < alloc && i < 22; i++) begin
			xfer(sgpsc_pkg::PH_DATA_IN, 8'h00, d);
			chkByte(d, expSense[i]);
		end
		fin(8'h00);
	endtask : sense

	// A good poll has one data byte; a refused one goes straight to status.
	task automatic poll(input logic ok);
		idyCnt = 0;
		ifcSeen = 1'b0;
		cmd(sgpsc_pkg::OP_PAR_POLL, 8'h00, 8'h00, 8'h00);
		if (ok) begin
			xfer(sgpsc_pkg::PH_DATA_IN, 8'h00, d);
			chkByte(d, PP_RESP);
			chkBit(idyCnt >= sgpsc_pkg::IDY_CYC, 1'b1);
			fin(8'h00);
		end else begin
			fin(8'h02);
			chkBit(idyCnt == 0 && !ifcSeen, 1'b1);
		end
	endtask : poll

	initial begin
		nrst = 1'b0;
		selected = 1'b0;
		hostAck = 1'b0;
		hostData = 8'h00;
		ifcIn = 1'b0;
		cicLost = 1'b0;
		unitStat = '{8'h3C, 8'hA5, 16'h1234, 32'h89AB_CDEF};
		expSense = '{8'h70, 0, 0, 0, 0, 0, 0, 8'h0E, 8'h3C, 8'hA5, 8'h12, 8'h34,
			0, 0, 0, 0, 0, 0, 8'h89, 8'hAB, 8'hCD, 8'hEF};
		repeat (8) @(posedge core_clk);
		#1 nrst = 1'b1;
		chkBit(sysCtl, 1'b1);
		poll(1'b1);
		chkBit(ifcSeen, 1'b1);
		chkBit(renOut, 1'b1);
		chkBit(cic, 1'b1);
		chkByte(pollRes, PP_RESP);
		sense(8'd22, sgpsc_pkg::KEY_NONE);
		ifcIn = 1'b1;
		repeat (4) @(posedge core_clk);
		#1 ifcIn = 1'b0;
		chkBit(cic, 1'b1);
		cmd(8'hAA, 8'h00, 8'h00, 8'h00);
		fin(8'h02);
		sense(8'd3, sgpsc_pkg::KEY_ILLEGAL);
		sense(8'd0, sgpsc_pkg::KEY_NONE);
		cmd(sgpsc_pkg::OP_SYS_CTL, 8'h5A, 8'hFE, 8'h00);
		fin(8'h00);
		chkBit(sysCtl, 1'b0);
		chkBit(renOut, 1'b0);
		chkBit(ifcOut, 1'b0);
		ifcIn = 1'b1;
		repeat (4) @(posedge core_clk);
		#1 ifcIn = 1'b0;
		chkBit(cic, 1'b0);
		cicLost = 1'b1;
		@(posedge core_clk);
		#1 cicLost = 1'b0;
		poll(1'b0);
		chkByte({4'h0, senseKey}, {4'h0, sgpsc_pkg::KEY_ERROR});
		sense(8'd3, sgpsc_pkg::KEY_ERROR);
		cmd(sgpsc_pkg::OP_SYS_CTL, 8'h00, 8'h01, 8'h00);
		fin(8'h00);
		chkBit(sysCtl, 1'b1);
		poll(1'b1);
		chkBit(ifcSeen, 1'b1);
		results();
	end
endmodule : sgpsc_ctrl_tb

`default_nettype wire
